// [rtl/ctm_timer.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - sixteen bit counter counts up only
// - period checks upper byte, match A all bits
// - timer on rise zeroes, fall holds count
// - overflow or selected match clears counter
// - count hold freezes, release resumes counting
// - clock source select picks count clock
// - timer off stops counter and prescalers
// - timer on rise restores initial pin level, except in pwm and timer modes
// - clock/run low three bits read zero
// - two-bit operating mode field
// - compare mode pin action on match A
// - pwm mode pin action selection
// - same-level match request shows no change
// - initial level bit: start level, pwm polarity
// - invert bit flips pin, not timer mode
// - swap bit exchanges duty and period roles
// - clear source: match A or period/overflow
// - pwm mode ignores clear source
// - timer mode leaves pin undriven
// - low byte write buffered until high write
// - high byte read latches low byte copy
// - clear on A raises only A flag
module ctm_timer
  import ctm_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // register port
  input  wire ctm_bus_req_s bus_req,
  output logic [7:0]        bus_rdata,
  // clock sources and count pin
  input  wire logic         high_clk,
  input  wire logic         sub_clk,
  input  wire logic         ext_count_input,
  // output pin and match events
  output logic              timer_output_pin,
  output logic              timer_output_en,
  output logic              match_a_flag,
  output logic              match_p_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]   clock_run;
  logic [7:0]   mode_out;
  logic [15:0]  count;
  logic [15:0]  match_a_value;
  logic [7:0]   period_match;
  logic [7:0]   byte_buf;
  logic         on_prev;
  logic         ext_prev;
  logic         high_prev;
  logic         sub_prev;
  logic [1:0]   sys_div;
  logic [5:0]   high_div;
  logic         pin_level;
  logic         next_level;

  logic         timer_on;
  logic         count_hold;
  ctm_clk_sel_e clock_source_select;
  ctm_mode_e    op_mode_select;
  ctm_action_e  pin_action_select;
  logic         pin_initial_level;
  logic         pin_invert;
  logic         duty_period_swap;
  logic         clear_source_select;
  logic         on_rise;
  logic         tick;
  logic [15:0]  count_inc;
  logic [15:0]  period_full;
  logic         hit_a;
  logic         hit_p;
  logic         clear_now;
  logic         flag_a;
  logic         flag_p;
  logic [15:0]  duty_full;
  logic         pwm_active;
  logic         next_pin;
  logic         next_drive;

  assign count_hold          = clock_run[CTM_BIT_COUNT_HOLD];
  assign clock_source_select = ctm_clk_sel_e'(clock_run[CTM_BIT_CLK_SEL_HI:CTM_BIT_CLK_SEL_LO]);
  assign timer_on            = clock_run[CTM_BIT_TIMER_ON];
  assign op_mode_select      = ctm_mode_e'(mode_out[CTM_BIT_MODE_HI:CTM_BIT_MODE_LO]);
  assign pin_action_select   = ctm_action_e'(mode_out[CTM_BIT_ACTION_HI:CTM_BIT_ACTION_LO]);
  assign pin_initial_level   = mode_out[CTM_BIT_INIT_LEVEL];
  assign pin_invert          = mode_out[CTM_BIT_INVERT];
  assign duty_period_swap    = mode_out[CTM_BIT_SWAP];
  assign clear_source_select = mode_out[CTM_BIT_CLEAR_SEL];
  assign on_rise             = rise(on_prev, timer_on);

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      on_prev   <= 1'b0;
      ext_prev  <= 1'b0;
      high_prev <= 1'b0;
      sub_prev  <= 1'b0;
    end else begin
      on_prev   <= timer_on;
      ext_prev  <= ext_count_input;
      high_prev <= high_clk;
      sub_prev  <= sub_clk;
    end
  end

  // ----------------------------------------------------------------
  // prescalers, idle while off
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !timer_on) begin
      sys_div  <= 2'h0;
      high_div <= 6'h00;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (rise(high_prev, high_clk)) begin
        high_div <= high_div + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // count clock select
  // ----------------------------------------------------------------
  always_comb begin
    unique case (clock_source_select)
      CTM_CLK_SYS_DIV4: tick = (sys_div == CTM_SYS_DIV4_LAST);
      CTM_CLK_SYS:      tick = 1'b1;
      CTM_CLK_HIGH_D16: tick = rise(high_prev, high_clk) &&
                               ((high_div & CTM_DIV16_MASK) == CTM_HIGH_DIV16_END);
      CTM_CLK_HIGH_D64: tick = rise(high_prev, high_clk) && (high_div == CTM_HIGH_DIV64_END);
      CTM_CLK_SUB_A,
      CTM_CLK_SUB_B:    tick = rise(sub_prev, sub_clk);
      CTM_CLK_EXT_RISE: tick = rise(ext_prev, ext_count_input);
      CTM_CLK_EXT_FALL: tick = rise(~ext_prev, ~ext_count_input);
    endcase
    tick = tick && timer_on && !count_hold && !on_rise;
  end

  // ----------------------------------------------------------------
  // comparators and clear decision
  // ----------------------------------------------------------------
  assign count_inc   = count + CTM_COUNT_ONE;
  assign period_full = {period_match, CTM_BYTE_ZERO};
  assign hit_a       = tick && (count_inc == match_a_value);
  assign hit_p       = tick && (count_inc == period_full);

  always_comb begin
    if (op_mode_select == CTM_MODE_PWM) begin
      clear_now = duty_period_swap ? hit_a : hit_p;
      flag_a    = hit_a;
      flag_p    = hit_p;
    end else if (clear_source_select) begin
      clear_now = hit_a;
      flag_a    = hit_a && (match_a_value != CTM_COUNT_ZERO);
      flag_p    = 1'b0;
    end else begin
      clear_now = hit_p;
      flag_a    = hit_a;
      flag_p    = hit_p;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= CTM_COUNT_ZERO;
    end else if (on_rise) begin
      count <= CTM_COUNT_ZERO;
    end else if (tick) begin
      count <= clear_now ? CTM_COUNT_ZERO : count_inc;
    end
  end

  // ----------------------------------------------------------------
  // match flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= flag_a;
      match_p_flag <= flag_p;
    end
  end

  // ----------------------------------------------------------------
  // compare mode pin level
  // ----------------------------------------------------------------
  always_comb begin
    next_level = pin_level;
    if (on_rise) begin
      next_level = pin_initial_level;
    end else if (flag_a && op_mode_select == CTM_MODE_COMPARE) begin
      unique case (pin_action_select)
        CTM_ACT_NONE:   next_level = pin_level;
        CTM_ACT_LOW:    next_level = 1'b0;
        CTM_ACT_HIGH:   next_level = 1'b1;
        CTM_ACT_TOGGLE: next_level = ~pin_level;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= next_level;
    end
  end

  // ----------------------------------------------------------------
  // pwm waveform and pin drive
  // ----------------------------------------------------------------
  assign duty_full  = duty_period_swap ? period_full : match_a_value;
  assign pwm_active = timer_on && (count < duty_full);

  always_comb begin
    next_drive = 1'b1;
    unique case (op_mode_select)
      CTM_MODE_COMPARE: next_pin = next_level;
      CTM_MODE_PWM: begin
        unique case (pin_action_select)
          CTM_ACT_LOW:  next_pin = pin_initial_level;
          CTM_ACT_HIGH: next_pin = pwm_active ? pin_initial_level : ~pin_initial_level;
          default:      next_pin = ~pin_initial_level;
        endcase
      end
      CTM_MODE_UNDEF: next_pin = pin_level;
      CTM_MODE_TIMER: begin
        next_pin   = 1'b0;
        next_drive = 1'b0;
      end
    endcase
    next_pin = next_drive & (next_pin ^ pin_invert);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_output_pin <= 1'b0;
      timer_output_en  <= 1'b0;
    end else begin
      timer_output_pin <= next_pin;
      timer_output_en  <= next_drive;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clock_run     <= CTM_CLOCK_RUN_RESET;
      mode_out      <= CTM_MODE_OUT_RESET;
      match_a_value <= CTM_MATCH_A_RESET;
      period_match  <= CTM_PERIOD_RESET;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        CTM_REG_CLOCK_RUN:  clock_run <= bus_req.wdata & CTM_CLOCK_RUN_MASK;
        CTM_REG_MODE_OUT:   mode_out <= bus_req.wdata;
        CTM_REG_MATCH_A_HI: match_a_value <= {bus_req.wdata, byte_buf};
        CTM_REG_PERIOD:     period_match <= bus_req.wdata;
        default:            clock_run <= clock_run;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shared low byte buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      byte_buf <= CTM_BYTE_ZERO;
    end else if (bus_req.wr && bus_req.addr == CTM_REG_MATCH_A_LOW) begin
      byte_buf <= bus_req.wdata;
    end else if (bus_req.rd && bus_req.addr == CTM_REG_COUNT_HIGH) begin
      byte_buf <= count[7:0];
    end else if (bus_req.rd && bus_req.addr == CTM_REG_MATCH_A_HI) begin
      byte_buf <= match_a_value[7:0];
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= CTM_BYTE_ZERO;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        CTM_REG_CLOCK_RUN:   bus_rdata <= clock_run & CTM_CLOCK_RUN_MASK;
        CTM_REG_MODE_OUT:    bus_rdata <= mode_out;
        CTM_REG_COUNT_LOW,
        CTM_REG_MATCH_A_LOW: bus_rdata <= byte_buf;
        CTM_REG_COUNT_HIGH:  bus_rdata <= count[15:8];
        CTM_REG_MATCH_A_HI:  bus_rdata <= match_a_value[15:8];
        CTM_REG_PERIOD:      bus_rdata <= period_match;
        default:             bus_rdata <= CTM_BYTE_ZERO;
      endcase
    end else begin
      bus_rdata <= CTM_BYTE_ZERO;
    end
  end

endmodule

// [rtl/ctm_pkg.sv]
package ctm_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] CTM_REG_CLOCK_RUN   = 3'h0;
  localparam logic [2:0] CTM_REG_MODE_OUT    = 3'h1;
  localparam logic [2:0] CTM_REG_COUNT_LOW   = 3'h2;
  localparam logic [2:0] CTM_REG_COUNT_HIGH  = 3'h3;
  localparam logic [2:0] CTM_REG_MATCH_A_LOW = 3'h4;
  localparam logic [2:0] CTM_REG_MATCH_A_HI  = 3'h5;
  localparam logic [2:0] CTM_REG_PERIOD      = 3'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTM_BIT_COUNT_HOLD  = 7;
  localparam int CTM_BIT_CLK_SEL_HI  = 6;
  localparam int CTM_BIT_CLK_SEL_LO  = 4;
  localparam int CTM_BIT_TIMER_ON    = 3;
  localparam int CTM_BIT_MODE_HI     = 7;
  localparam int CTM_BIT_MODE_LO     = 6;
  localparam int CTM_BIT_ACTION_HI   = 5;
  localparam int CTM_BIT_ACTION_LO   = 4;
  localparam int CTM_BIT_INIT_LEVEL  = 3;
  localparam int CTM_BIT_INVERT      = 2;
  localparam int CTM_BIT_SWAP        = 1;
  localparam int CTM_BIT_CLEAR_SEL   = 0;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTM_CLOCK_RUN_RESET = 8'h00;
  localparam logic [7:0]  CTM_MODE_OUT_RESET  = 8'h00;
  localparam logic [7:0]  CTM_CLOCK_RUN_MASK  = 8'hf8;
  localparam logic [15:0] CTM_MATCH_A_RESET   = 16'h0000;
  localparam logic [7:0]  CTM_PERIOD_RESET    = 8'h00;
  localparam logic [7:0]  CTM_BYTE_ZERO       = 8'h00;
  localparam logic [15:0] CTM_COUNT_ZERO      = 16'h0000;
  localparam logic [15:0] CTM_COUNT_ONE       = 16'h0001;

  // ----------------------------------------------------------------
  // prescaler counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CTM_SYS_DIV4_LAST  = 2'h3;
  localparam logic [5:0] CTM_HIGH_DIV16_END = 6'h0f;
  localparam logic [5:0] CTM_HIGH_DIV64_END = 6'h3f;
  localparam logic [5:0] CTM_DIV16_MASK     = 6'h0f;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CTM_MODE_COMPARE = 2'b00,
    CTM_MODE_UNDEF   = 2'b01,
    CTM_MODE_PWM     = 2'b10,
    CTM_MODE_TIMER   = 2'b11
  } ctm_mode_e;

  typedef enum logic [2:0] {
    CTM_CLK_SYS_DIV4  = 3'b000,
    CTM_CLK_SYS       = 3'b001,
    CTM_CLK_HIGH_D16  = 3'b010,
    CTM_CLK_HIGH_D64  = 3'b011,
    CTM_CLK_SUB_A     = 3'b100,
    CTM_CLK_SUB_B     = 3'b101,
    CTM_CLK_EXT_RISE  = 3'b110,
    CTM_CLK_EXT_FALL  = 3'b111
  } ctm_clk_sel_e;

  typedef enum logic [1:0] {
    CTM_ACT_NONE   = 2'b00,
    CTM_ACT_LOW    = 2'b01,
    CTM_ACT_HIGH   = 2'b10,
    CTM_ACT_TOGGLE = 2'b11
  } ctm_action_e;

  // ----------------------------------------------------------------
  // register bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctm_bus_req_s;

endpackage

// [sim/ctm_timer_checker.sv]
`timescale 1ns/100ps
module ctm_timer_checker
  import ctm_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire ctm_bus_req_s bus_req,
  input wire logic [7:0]   bus_rdata,
  input wire logic         timer_output_pin,
  input wire logic         timer_output_en,
  input wire logic         match_a_flag,
  input wire logic         match_p_flag
);
  logic [7:0] c0;
  logic [7:0] c1;
  always_ff @(posedge clk) begin
    if (!resetn) c0 <= 8'h00;
    else if (bus_req.wr && bus_req.addr == CTM_REG_CLOCK_RUN) c0 <= bus_req.wdata;
  end
  always_ff @(posedge clk) begin
    if (!resetn) c1 <= 8'h00;
    else if (bus_req.wr && bus_req.addr == CTM_REG_MODE_OUT) c1 <= bus_req.wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle_zero: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data not zero");
  a_ctrl_low_zero: assert property ((bus_req.rd && bus_req.addr == CTM_REG_CLOCK_RUN) |=>
    bus_rdata[2:0] == 3'h0) else $error("unused bits not zero");
  a_timer_undriven: assert property ((c1[7:6] == CTM_MODE_TIMER && $past(c1[7:6]) == CTM_MODE_TIMER)
    |-> !timer_output_en && !timer_output_pin) else $error("pin driven in timer mode");
  a_pin_driven_on: assert property (($past(resetn) && c1[7:6] != CTM_MODE_TIMER
    && $past(c1[7:6]) != CTM_MODE_TIMER) |-> timer_output_en) else $error("pin not driven");
  a_no_p_flag: assert property ((c1[0] && c1[7:6] != CTM_MODE_PWM && c1 == $past(c1))
    |-> !match_p_flag) else $error("period flag on clear by A");
  a_off_no_flags: assert property ((!c0[3] && !$past(c0[3]) && !$past(c0[3], 2))
    |-> !match_a_flag && !match_p_flag) else $error("flag while off");
  a_on_init_level: assert property (($rose(c0[3]) && c1[7:6] == CTM_MODE_COMPARE)
    |-> ##[1:3] timer_output_pin == (c1[3] ^ c1[2])) else $error("pin not at initial level");
  a_pwm_forced: assert property ((c1[7:6] == CTM_MODE_PWM && !c1[5] && c0[3] && $past(c0[3], 3)
    && c1 == $past(c1, 3)) |-> timer_output_pin == ((c1[4] ? c1[3] : !c1[3]) ^ c1[2]))
    else $error("forced pwm level wrong");
endmodule
bind ctm_timer ctm_timer_checker u_chk (.clk(clk), .resetn(resetn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .timer_output_pin(timer_output_pin), .timer_output_en(timer_output_en),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// [sim/ctm_pin_model.sv]
`timescale 1ns/100ps
module ctm_pin_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic timer_output_pin,
  input  wire logic timer_output_en,
  output logic      ext_count_input,
  output logic      pin_seen
);
  logic [1:0] ph;
  initial begin
    ext_count_input = 1'h0;
    ph = 2'h0;
  end
  // square wave, one rising edge every six clocks, low when idle
  always @(posedge clk) begin
    if (!run) begin
      ph <= 2'h0;
      ext_count_input <= 1'h0;
    end else if (ph == 2'h2) begin
      ph <= 2'h0;
      ext_count_input <= !ext_count_input;
    end else ph <= ph + 2'h1;
  end
  // released pin pulled high
  assign pin_seen = timer_output_en ? timer_output_pin : 1'h1;
endmodule

// [sim/ctm_timer_tb_top.sv]
`timescale 1ns/100ps
module ctm_timer_tb_top
  import ctm_pkg::*;
;
  logic         clk = 1'h0;
  logic         resetn = 1'h0;
  ctm_bus_req_s bus_req = '0;
  logic [7:0]   bus_rdata;
  logic         hck = 1'h0;
  logic         sck = 1'h0;
  logic         run = 1'h0;
  logic         ext, pin, en, fa, fp, pin_seen, rd_prev, x;
  logic [15:0]  exq[$];
  logic [15:0]  e, d;
  logic [7:0]   hist[2];
  logic [7:0]   h, l;
  logic [31:0]  lf = 32'h31e3_c56a;
  int           dv[8] = '{4, 1, 32, 128, 2, 2, 6, 6};
  int           n_fail = 0, comparisons = 0, cyc = 0, n;
  ctm_timer uut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata), .high_clk(hck),
    .sub_clk(sck), .ext_count_input(ext), .timer_output_pin(pin), .timer_output_en(en),
    .match_a_flag(fa), .match_p_flag(fp));
  ctm_pin_model u_pin (.clk(clk), .run(run), .timer_output_pin(pin), .timer_output_en(en),
    .ext_count_input(ext), .pin_seen(pin_seen));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    hck <= ~hck;
    sck <= ~sck;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic test_done;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [2:0] a, input logic [7:0] dt, input logic w);
    bus_req <= '{addr: a, wdata: dt, wr: w, rd: !w};
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dt);
    op(a, dt, 1'h1);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] ex, input logic [7:0] m);
    exq.push_back({m, ex});
    op(a, 8'h00, 1'h0);
  endtask
  task automatic idle(input int c);
    bus_req <= '0;
    repeat (c) @(posedge clk);
  endtask
  task automatic wflag(input logic p, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((p ? fp : fa) !== 1'h1 && c < 2000);
  endtask
  task automatic start(input logic [15:0] a, input logic [7:0] m1, input logic [2:0] src);
    wr(CTM_REG_CLOCK_RUN, 8'h00);
    wr(CTM_REG_MATCH_A_LOW, a[7:0]);
    wr(CTM_REG_MATCH_A_HI, a[15:8]);
    wr(CTM_REG_MODE_OUT, m1);
    wr(CTM_REG_CLOCK_RUN, {1'h0, src, 1'h1, 3'h0});
    idle(1);
  endtask
  task automatic grab;
    rd(CTM_REG_COUNT_HIGH, 8'h00, 8'h00);
    rd(CTM_REG_COUNT_LOW, 8'h00, 8'h00);
    idle(2);
    h = hist[1];
    l = hist[0];
  endtask
  // read results, one cycle after each read strobe
  always @(negedge clk) begin
    if (rd_prev === 1'h1) begin
      hist[1] = hist[0];
      hist[0] = bus_rdata;
      e = exq.pop_front();
      chk({8'h00, bus_rdata & e[15:8]}, {8'h00, e[7:0]});
    end
    rd_prev = bus_req.rd;
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00, 8'hff);
    wr(CTM_REG_CLOCK_RUN, 8'hf7);
    rd(CTM_REG_CLOCK_RUN, 8'hf0, 8'hff);
    lf = nxt(lf);
    wr(CTM_REG_PERIOD, lf[7:0]);
    wr(CTM_REG_MODE_OUT, lf[15:8]);
    wr(CTM_REG_MATCH_A_LOW, lf[23:16]);
    wr(CTM_REG_MATCH_A_HI, lf[31:24]);
    rd(CTM_REG_PERIOD, lf[7:0], 8'hff);
    rd(CTM_REG_MODE_OUT, lf[15:8], 8'hff);
    rd(CTM_REG_MATCH_A_HI, lf[31:24], 8'hff);
    rd(CTM_REG_MATCH_A_LOW, lf[23:16], 8'hff);
    wr(CTM_REG_MATCH_A_LOW, ~lf[23:16]);
    wr(3'h7, 8'hff);
    rd(CTM_REG_MATCH_A_HI, lf[31:24], 8'hff);
    rd(CTM_REG_MATCH_A_LOW, lf[23:16], 8'hff);
    rd(3'h7, 8'h00, 8'hff);
    wr(CTM_REG_PERIOD, 8'h01);
    run <= 1'h1;
    for (int s = 0; s < 8; s++) begin
      start(16'h0003, 8'h01, s[2:0]);
      wflag(1'h0, n);
      wflag(1'h0, n);
      chk(n[15:0], 16'(3 * dv[s]));
    end
    for (int a = 1; a < 4; a++) for (int k = 0; k < 4; k++) begin
      start(16'h0003, {2'h0, a[1:0], k[0], k[1], 2'h1}, 3'h1);
      for (int j = 1; j < 3; j++) begin
        wflag(1'h0, n);
        x = a == 1 ? 1'h0 : a == 2 ? 1'h1 : k[0] ^ j[0];
        chk({15'h0000, pin_seen}, {15'h0000, x ^ k[1]});
      end
    end
    start(16'h0010, 8'h00, 3'h1);
    wflag(1'h1, n);
    wflag(1'h1, n);
    chk(n[15:0], 16'h0100);
    start(16'h0003, 8'ha2, 3'h1);
    wflag(1'h0, n);
    wflag(1'h0, n);
    chk(n[15:0], 16'h0003);
    start(16'h0000, 8'h01, 3'h1);
    idle(300);
    wr(CTM_REG_CLOCK_RUN, 8'h98);
    grab;
    idle(20);
    rd(CTM_REG_COUNT_HIGH, h, 8'hff);
    rd(CTM_REG_COUNT_LOW, l, 8'hff);
    d = {h, l};
    wr(CTM_REG_CLOCK_RUN, 8'h18);
    idle(300);
    wr(CTM_REG_CLOCK_RUN, 8'h10);
    grab;
    d = {h, l} - d;
    chk({15'h0000, d >= 16'h012a && d <= 16'h0130}, 16'h0001);
    idle(20);
    rd(CTM_REG_COUNT_HIGH, h, 8'hff);
    rd(CTM_REG_COUNT_LOW, l, 8'hff);
    wr(CTM_REG_CLOCK_RUN, 8'h18);
    idle(1);
    rd(CTM_REG_COUNT_HIGH, 8'h00, 8'hff);
    rd(CTM_REG_COUNT_LOW, 8'h00, 8'hf0);
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      start(16'h0003, {3'h4, k[0], k[1], lf[2], 2'h0}, 3'h1);
      idle(6);
    end
    start(16'h0003, 8'hc1, 3'h1);
    idle(6);
    chk({15'h0000, pin_seen}, 16'h0001);
    idle(3);
    test_done;
  end
endmodule
